// ==== include/lwli_cfg.svh ====
/*
 * lwli_cfg.svh: timing figures, codes and bit positions of the LIN
 * wake and level input block.
 * Assumes a 125 MHz system clock and a 1 MHz internal oscillator tick.
 */
`ifndef LWLI_CFG_SVH
`define LWLI_CFG_SVH

// system clock and internal oscillator
`define LWLI_CLK_PERIOD_NS   (1000 / 125)
`define LWLI_OSC_PERIOD_NS   1000
`define LWLI_OSC_DIV         (`LWLI_OSC_PERIOD_NS * 125 / 1000)

// bus wake deglitch window in microseconds
`define LWLI_FILT_MIN_US     30
`define LWLI_FILT_MAX_US     90
// least time rounds up to whole oscillator ticks
`define LWLI_FILT_TICKS      ((`LWLI_FILT_MIN_US * 1000 + `LWLI_OSC_PERIOD_NS - 1) / `LWLI_OSC_PERIOD_NS)

// report delay after the closing rising edge, oscillator ticks
`define LWLI_REPORT_TICKS    2

// interrupt low pulse, typical figure
`define LWLI_INT_LOW_US      10
`define LWLI_INT_TICKS       ((`LWLI_INT_LOW_US * 1000) / `LWLI_OSC_PERIOD_NS)

// serial frame length and slew codes carried in its low bits
`define LWLI_SPI_BITS        8
`define LWLI_SLEW_NORMAL     2'h0
`define LWLI_SLEW_SLOW       2'h1
`define LWLI_SLEW_FAST       2'h2
`define LWLI_SLEW_BAD        2'h3

// bit positions in the pin input vector
`define LWLI_PIN_MOSI        0
`define LWLI_PIN_SCLK        1
`define LWLI_PIN_CS_N        2
`define LWLI_PIN_LVL2        3
`define LWLI_PIN_LVL1        4
`define LWLI_PIN_TXD         5
`define LWLI_PIN_LIN         6
`define LWLI_PIN_W           7

`endif

// ==== include/lwli_pkg.sv ====
/*
 * lwli_pkg: types of the LIN wake and level input block.
 * Assumes lwli_cfg.svh is on the include path.
 */
`include "lwli_cfg.svh"

package lwli_pkg;

	// operating mode driven by the chip's mode controller
	typedef enum logic [1:0] {
		LWLI_MODE_NORMAL,
		LWLI_MODE_SLEEP,
		LWLI_MODE_STOP
	} lwli_mode_t;

	// bus wake detector states
	typedef enum logic [1:0] {
		LWLI_WK_IDLE,
		LWLI_WK_ARMED,
		LWLI_WK_DELAY
	} lwli_wake_t;

	// raw pins from outside the clock domain
	typedef struct packed {
		logic lin_in;     // bus level, low is dominant
		logic txd;        // transmit input, low drives dominant
		logic lvl1;       // level_input_one
		logic lvl2;       // level_input_two
		logic cs_n;       // serial chip select
		logic sclk;       // serial clock
		logic mosi;       // serial data in
	} lwli_pins_t;

	// whole state of the block
	typedef struct packed {
		logic [`LWLI_PIN_W-1:0] s1;        // sync stage one
		logic [`LWLI_PIN_W-1:0] s2;        // sync stage two
		logic [`LWLI_PIN_W-1:0] s3;        // sync stage three
		logic [`LWLI_PIN_W-1:0] flt;       // agreed pin levels
		logic [`LWLI_PIN_W-1:0] flt_prev;  // agreed levels last cycle
		logic [7:0]             osc_cnt;   // oscillator divider
		lwli_wake_t             wk;        // bus wake state
		logic [7:0]             filt_cnt;  // dominant ticks counted
		logic [7:0]             rep_cnt;   // ticks since rising edge
		logic [7:0]             int_cnt;   // interrupt low ticks
		lwli_mode_t             mode_prev; // mode last cycle
		logic                   int_n;     // interrupt output
		logic                   vdd_en;    // regulator enable
		logic                   wake_pulse;
		logic [1:0]             level;     // readable level states
		logic                   lin_dom;   // drive bus dominant
		logic                   rxd;       // receive output
		logic [1:0]             slew;      // slew selection
		logic [7:0]             tx_sh;     // serial out shifter
		logic [7:0]             rx_sh;     // serial in shifter
		logic [3:0]             bit_cnt;   // bits sampled in frame
		logic                   miso;
		logic                   miso_oe;
	} lwli_state_t;

endpackage : lwli_pkg

// ==== logic/lwli_top.sv ====
/*
 * lwli_top: LIN bus wake detector, level input sensing, LIN pin
 * pass-through with slew selection and a small serial status port.
 * Assumes a mode controller drives mode on clk_sys and the analog
 * transceiver turns lin_dom and slew_sel into the bus waveform.
 */
`include "lwli_cfg.svh"

// Functional notes
// - deglitch bus wake, 30 to 90 us
// - report wake two oscillator ticks after rise
// - stop mode wake pulls interrupt low
// - sleep mode wake restarts supply regulator
// - sample data falling edge, launch rising
// - level inputs wake from sleep, stop
// - normal mode exposes both level states
// - fast, normal and slow slew settings
// - receive output follows bus level
// - transmit low drives bus dominant in normal mode
module lwli_top #(
	parameter logic [7:0] OSC_DIV = 8'(`LWLI_OSC_DIV)  // clk cycles per tick
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire lwli_pkg::lwli_pins_t pins,
	input  wire lwli_pkg::lwli_mode_t mode,
	output wire logic               lin_dom,
	output wire logic               rxd,
	output wire logic               int_n,
	output wire logic               vdd_en,
	output wire logic               wake_pulse,
	output wire logic [1:0]         level_state,
	output wire logic [1:0]         slew_sel,
	output wire logic               miso,
	output wire logic               miso_oe
);
	import lwli_pkg::*;

	lwli_state_t state_reg;   // all registered state
	lwli_state_t state_next;  // its next value

	// timing figures in oscillator ticks, frame length in bits
	localparam logic [7:0] FILT_TICKS = 8'(`LWLI_FILT_TICKS);
	localparam logic [7:0] REP_TICKS  = 8'(`LWLI_REPORT_TICKS);
	localparam logic [7:0] INT_TICKS  = 8'(`LWLI_INT_TICKS);
	localparam logic [3:0] SPI_BITS   = 4'(`LWLI_SPI_BITS);

	////////////////////////////////////////////////////////////////////////
	// next state
	////////////////////////////////////////////////////////////////////////

	logic       tick;        // one internal oscillator cycle
	logic       low_power;   // sleep or stop
	logic       bus_dom;     // agreed bus level is dominant
	logic       fire;        // any accepted wake event
	logic [`LWLI_PIN_W-1:0] raw;  // pins as a vector
	logic [`LWLI_PIN_W-1:0] dif;  // stages two and three disagree
	logic       cs_fall;
	logic       cs_rise;
	logic       sck_rise;
	logic       sck_fall;

	// one process computes every next value
	always_comb begin
		state_next = state_reg;
		raw = {pins.lin_in, pins.txd, pins.lvl1, pins.lvl2,
			pins.cs_n, pins.sclk, pins.mosi};

		// three flops; a change counts once stages two and three agree
		state_next.s1 = raw;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		dif = state_reg.s2 ^ state_reg.s3;
		state_next.flt = (~dif & state_reg.s3) | (dif & state_reg.flt);
		state_next.flt_prev = state_reg.flt;
		state_next.mode_prev = mode;
		state_next.wake_pulse = 1'b0;

		// oscillator tick from the system clock divider
		tick = (state_reg.osc_cnt == OSC_DIV - 8'h01);
		if (tick) begin
			state_next.osc_cnt = 8'h00;
		end else begin
			state_next.osc_cnt = state_reg.osc_cnt + 8'h01;
		end

		low_power = (mode != LWLI_MODE_NORMAL);
		bus_dom = ~state_reg.flt[`LWLI_PIN_LIN];
		fire = 1'b0;

		// bus wake detector
		unique case (state_reg.wk)
			LWLI_WK_IDLE: begin
				if (!low_power || !bus_dom) begin
					state_next.filt_cnt = 8'h00;
				end else if (tick) begin
					state_next.filt_cnt = state_reg.filt_cnt + 8'h01;
					// accept after least filter time
					// one extra tick: the first tick may land right after the edge
					if (state_reg.filt_cnt == FILT_TICKS) begin
						state_next.wk = LWLI_WK_ARMED;
					end
				end
			end
			LWLI_WK_ARMED: begin
				// wait for the rising edge closing the pulse
				state_next.filt_cnt = 8'h00;
				if (!low_power) begin
					state_next.wk = LWLI_WK_IDLE;
				end else if (!bus_dom) begin
					state_next.rep_cnt = 8'h00;
					state_next.wk = LWLI_WK_DELAY;
				end
			end
			LWLI_WK_DELAY: begin
				if (!low_power) begin
					state_next.wk = LWLI_WK_IDLE;
				end else if (tick) begin
					state_next.rep_cnt = state_reg.rep_cnt + 8'h01;
					if (state_reg.rep_cnt == REP_TICKS - 8'h01) begin
						fire = 1'b1;
						state_next.wk = LWLI_WK_IDLE;
					end
				end
			end
		endcase

		// level input change wakes the chip
		if (low_power && (state_reg.flt[`LWLI_PIN_LVL1:`LWLI_PIN_LVL2] !=
				state_reg.flt_prev[`LWLI_PIN_LVL1:`LWLI_PIN_LVL2])) begin
			fire = 1'b1;
		end

		// interrupt low pulse times out on oscillator ticks
		if (!state_reg.int_n && tick) begin
			state_next.int_cnt = state_reg.int_cnt + 8'h01;
			if (state_reg.int_cnt == INT_TICKS - 8'h01) begin
				state_next.int_n = 1'b1;
			end
		end

		// regulator is on outside sleep, dropped on entering sleep
		if (mode != LWLI_MODE_SLEEP) begin
			state_next.vdd_en = 1'b1;
		end else if (state_reg.mode_prev != LWLI_MODE_SLEEP) begin
			state_next.vdd_en = 1'b0;
		end

		// wake report; set wins over the clears above
		if (fire) begin
			state_next.wake_pulse = 1'b1;
			if (mode == LWLI_MODE_STOP) begin
				state_next.int_n = 1'b0;
				state_next.int_cnt = 8'h00;
			end
			if (mode == LWLI_MODE_SLEEP) begin
				state_next.vdd_en = 1'b1;
			end
		end

		// level states tracked in normal mode
		if (!low_power) begin
			state_next.level = state_reg.flt[`LWLI_PIN_LVL1:`LWLI_PIN_LVL2];
		end

		state_next.rxd = state_reg.flt[`LWLI_PIN_LIN];
		// transmit low drives dominant; silent when asleep
		state_next.lin_dom = ~low_power & ~state_reg.flt[`LWLI_PIN_TXD];

		// serial port edges from agreed levels
		cs_fall  = state_reg.flt_prev[`LWLI_PIN_CS_N] & ~state_reg.flt[`LWLI_PIN_CS_N];
		cs_rise  = ~state_reg.flt_prev[`LWLI_PIN_CS_N] & state_reg.flt[`LWLI_PIN_CS_N];
		sck_rise = ~state_reg.flt_prev[`LWLI_PIN_SCLK] & state_reg.flt[`LWLI_PIN_SCLK];
		sck_fall = state_reg.flt_prev[`LWLI_PIN_SCLK] & ~state_reg.flt[`LWLI_PIN_SCLK];

		if (cs_fall) begin
			// frame start: load level states, enable output
			state_next.tx_sh = {6'h00, state_reg.level};
			state_next.bit_cnt = 4'h0;
			state_next.miso = 1'b0;
			state_next.miso_oe = 1'b1;
		end else if (!state_reg.flt[`LWLI_PIN_CS_N]) begin
			if (sck_rise) begin
				state_next.miso = state_reg.tx_sh[7];
				state_next.tx_sh = {state_reg.tx_sh[6:0], 1'b0};
			end
			if (sck_fall && state_reg.bit_cnt != SPI_BITS) begin
				state_next.rx_sh = {state_reg.rx_sh[6:0],
					state_reg.flt[`LWLI_PIN_MOSI]};
				state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
			end
		end

		if (cs_rise) begin
			state_next.miso_oe = 1'b0;
			state_next.miso = 1'b0;
			// slew set by a full frame in normal mode
			if (!low_power && state_reg.bit_cnt == SPI_BITS &&
					state_reg.rx_sh[1:0] != `LWLI_SLEW_BAD) begin
				state_next.slew = state_reg.rx_sh[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	////////////////////////////////////////////////////////////////////////

	// pins idle high (recessive bus, deselected port) out of reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{
				s1: {`LWLI_PIN_W{1'b1}}, s2: {`LWLI_PIN_W{1'b1}},
				s3: {`LWLI_PIN_W{1'b1}}, flt: {`LWLI_PIN_W{1'b1}},
				flt_prev: {`LWLI_PIN_W{1'b1}}, osc_cnt: 8'h00,
				wk: LWLI_WK_IDLE, filt_cnt: 8'h00, rep_cnt: 8'h00,
				int_cnt: 8'h00, mode_prev: LWLI_MODE_NORMAL,
				int_n: 1'b1, vdd_en: 1'b1, wake_pulse: 1'b0,
				level: 2'h0, lin_dom: 1'b0, rxd: 1'b1,
				slew: `LWLI_SLEW_NORMAL, tx_sh: 8'h00, rx_sh: 8'h00,
				bit_cnt: 4'h0, miso: 1'b0, miso_oe: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign lin_dom     = state_reg.lin_dom;
	assign rxd         = state_reg.rxd;
	assign int_n       = state_reg.int_n;
	assign vdd_en      = state_reg.vdd_en;
	assign wake_pulse  = state_reg.wake_pulse;
	assign level_state = state_reg.level;
	assign slew_sel    = state_reg.slew;
	assign miso        = state_reg.miso;
	assign miso_oe     = state_reg.miso_oe;

endmodule : lwli_top

// ==== verification/lwli_assertions.sv ====
/* lwli_checker: concurrent checks on the ports of lwli_top.
   assumes binding into lwli_top and one clock domain clk_sys. */
module lwli_checker
	import lwli_pkg::*;
#(
	parameter logic [7:0] OSC_DIV = 8'h7d  // clk cycles per tick
) (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire lwli_pins_t pins,
	input wire lwli_mode_t mode,
	input wire logic       lin_dom,
	input wire logic       rxd,
	input wire logic       int_n,
	input wire logic       vdd_en,
	input wire logic       wake_pulse,
	input wire logic [1:0] level_state,
	input wire logic [1:0] slew_sel,
	input wire logic       miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// sync plus two ticks, with margin for tick phase
	localparam int REP_MAX = 3 * OSC_DIV + 8;
	logic [15:0] dom_cnt;  // pin dominance while asleep, in clk cycles
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// saturating count so a stuck bus cannot wrap into a short pulse
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			dom_cnt <= 16'h0000;
		else if (pins.lin_in || mode == LWLI_MODE_NORMAL)
			dom_cnt <= 16'h0000;
		else if (dom_cnt != 16'hffff)
			dom_cnt <= dom_cnt + 16'h0001;
	end
	rxd_follow_a: assert property ($stable(pins.lin_in)[*8] |-> rxd == pins.lin_in)
		else $error("receive output off bus level");
	txd_drive_a: assert property ((mode == LWLI_MODE_NORMAL && $stable(pins.txd))[*8]
		|-> lin_dom == !pins.txd) else $error("bus drive off transmit input");
	quiet_bus_a: assert property ((mode != LWLI_MODE_NORMAL)[*2] |-> !lin_dom)
		else $error("bus driven while asleep");
	filter_block_a: assert property ($rose(pins.lin_in) && dom_cnt < 16'(20 * OSC_DIV)
		|-> !wake_pulse[*8] ##1 !wake_pulse[*8]) else $error("short pulse woke");
	report_delay_a: assert property ($rose(pins.lin_in) && dom_cnt > 16'(33 * OSC_DIV)
		|-> ##[3:REP_MAX] wake_pulse) else $error("bus wake not reported");
	stop_int_a: assert property (wake_pulse && mode == LWLI_MODE_STOP |-> !int_n)
		else $error("stop wake without interrupt");
	sleep_vdd_a: assert property (wake_pulse && mode == LWLI_MODE_SLEEP |-> vdd_en)
		else $error("sleep wake without regulator");
	level_show_a: assert property ((mode == LWLI_MODE_NORMAL
		&& $stable({pins.lvl1, pins.lvl2}))[*8] |-> level_state == {pins.lvl1, pins.lvl2})
		else $error("level state stale");
	slew_update_a: assert property ($changed(slew_sel) |-> slew_sel != 2'h3
		&& mode == LWLI_MODE_NORMAL && $past(miso_oe, 2)) else $error("slew changed wrongly");
endmodule : lwli_checker

// ==== verification/lwli_lin_node.sv ====
/* lwli_lin_node: single-wire bus with pull-up and one remote node.
   assumes both pull-down requests are active high. */
module lwli_lin_node (
	input  wire logic lin_dom,   // transceiver pulls low
	input  wire logic node_dom,  // remote node pulls low
	output wire logic lin_level  // wire level seen by receiver
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////
	// wired bus, pull-up
	assign lin_level = !(lin_dom || node_dom);
endmodule : lwli_lin_node

// ==== verification/testbench.sv ====
/* testbench: scenarios for lwli_top against a bus node model.
   assumes the design package and header on the include path. */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import lwli_pkg::*;
	localparam logic [7:0] DIV = 8'h04;  // short tick keeps the run brief
	logic       clk_sys, rst_n, txd, lvl1, lvl2, cs_n, sclk, mosi, node_dom, lin_level;
	logic       lin_dom, rxd, int_n, vdd_en, wake_pulse, miso, miso_oe, int_seen, vdd_seen;
	logic [1:0] level_state, slew_sel;
	lwli_mode_t mode;
	lwli_pins_t pins;
	int         num_errors, n_tests;
	bit         seen;  // a wake pulse was caught
	assign pins = {lin_level, txd, lvl1, lvl2, cs_n, sclk, mosi};
	lwli_top #(.OSC_DIV(DIV)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
		.mode(mode), .lin_dom(lin_dom), .rxd(rxd), .int_n(int_n), .vdd_en(vdd_en),
		.wake_pulse(wake_pulse), .level_state(level_state), .slew_sel(slew_sel),
		.miso(miso), .miso_oe(miso_oe));
	lwli_lin_node i_node (.lin_dom(lin_dom), .node_dom(node_dom), .lin_level(lin_level));
	////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk8
	// watch falling edges so registered outputs have settled
	task wait_pulse(input int n);
		seen = 1'b0;
		repeat (n) begin
			@(negedge clk_sys);
			if (wake_pulse === 1'b1) begin
				seen = 1'b1;
				int_seen = int_n;
				vdd_seen = vdd_en;
			end
		end
	endtask : wait_pulse
	// remote node holds the bus dominant for a number of ticks
	task t_bus(input int ticks, input lwli_mode_t m, input bit exp);
		cyc(1);
		mode <= m;
		cyc(12);
		node_dom <= 1'b1;
		if (m == LWLI_MODE_SLEEP) chk8({7'h00, vdd_en}, 8'h00);
		wait_pulse(ticks * DIV);
		chk8({7'h00, seen}, 8'h00);
		cyc(1);
		node_dom <= 1'b0;
		wait_pulse(40);
		chk8({7'h00, seen}, {7'h00, exp});
	endtask : t_bus
	task t_level;
		cyc(1);
		mode <= LWLI_MODE_NORMAL;
		cyc(2);
		mode <= LWLI_MODE_SLEEP;
		cyc(12);
		lvl1 <= 1'b0;
		wait_pulse(20);
		chk8({6'h00, seen, vdd_seen}, 8'h03);
		cyc(1);
		mode <= LWLI_MODE_STOP;
		cyc(50);
		lvl2 <= 1'b0;
		wait_pulse(20);
		chk8({6'h00, seen, int_seen}, 8'h02);
		cyc(1);
		mode <= LWLI_MODE_NORMAL;
		lvl2 <= 1'b1;
		cyc(12);
		chk8({6'h00, level_state}, 8'h01);
	endtask : t_level
	task t_txrx;
		cyc(1);
		txd <= 1'b0;
		cyc(14);
		chk8({6'h00, lin_dom, rxd}, 8'h02);
		txd <= 1'b1;
		cyc(14);
		chk8({6'h00, lin_dom, rxd}, 8'h01);
	endtask : t_txrx
	// host launches on the rising clock edge, device samples on the falling one
	task t_spi(input logic [7:0] cmd, input logic [1:0] exp_slew);
		logic [7:0] got;
		cyc(1);
		cs_n <= 1'b0;
		cyc(10);
		chk8({7'h00, miso_oe}, 8'h01);
		for (int i = 7; i >= 0; i--) begin
			sclk <= 1'b1;
			mosi <= cmd[i];
			cyc(10);
			got[i] = miso;
			sclk <= 1'b0;
			cyc(10);
		end
		cs_n <= 1'b1;
		cyc(12);
		chk8({7'h00, miso_oe}, 8'h00);
		chk8(got, 8'h01);
		chk8({6'h00, slew_sel}, {6'h00, exp_slew});
	endtask : t_spi
	task wrap_up;
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////
	initial begin
		{txd, lvl1, lvl2, cs_n} = 4'hf;
		{sclk, mosi, node_dom, rst_n} = 4'h0;
		mode = LWLI_MODE_NORMAL;
		cyc(2);
		rst_n <= 1'b1;
		t_txrx();
		t_bus(15, LWLI_MODE_STOP, 1'b0);
		t_bus(34, LWLI_MODE_STOP, 1'b1);
		chk8({7'h00, int_seen}, 8'h00);
		t_bus(34, LWLI_MODE_SLEEP, 1'b1);
		chk8({7'h00, vdd_seen}, 8'h01);
		t_level();
		t_spi(8'h02, 2'h2);
		t_spi(8'h01, 2'h1);
		t_spi(8'h03, 2'h1);
		t_spi(8'h00, 2'h0);
		wrap_up();
	end
	// the scenarios need about 1400 cycles
	initial begin
		repeat (6000) @(posedge clk_sys);
		num_errors++;
		wrap_up();
	end
endmodule : testbench

bind lwli_top lwli_checker #(.OSC_DIV(OSC_DIV)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.pins(pins), .mode(mode), .lin_dom(lin_dom), .rxd(rxd), .int_n(int_n), .vdd_en(vdd_en),
	.wake_pulse(wake_pulse), .level_state(level_state), .slew_sel(slew_sel),
	.miso_oe(miso_oe));
